/* File: common/sram_ctl_pkg.sv */
// Purpose: shared constants for the static ram host controller
// Assumes: 200 MHz ref_clk, 5 ns period
// Notes: times in ns, cycle counts derived from them
package sram_ctl_pkg;
  localparam int unsigned clk_period_ns = 5;
  localparam int unsigned addr_w = 8;
  localparam int unsigned word_count = 256;
  // address stable before write strobe rises
  localparam int unsigned addr_setup_ns = 300;
  // write strobe width
  localparam int unsigned write_pulse_ns = 400;
  // data stable before strobe ends
  localparam int unsigned data_setup_ns = 300;
  // address and data hold after strobe
  localparam int unsigned hold_ns = 100;
  // address to output access time for reads
  localparam int unsigned access_ns = 1500;
  localparam int unsigned addr_setup_cyc = (addr_setup_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned write_pulse_cyc = (write_pulse_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned data_setup_cyc = (data_setup_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned hold_cyc = (hold_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned access_cyc = (access_ns + clk_period_ns - 1) / clk_period_ns;
  localparam int unsigned cnt_w = 9;
  typedef enum logic [2:0] {st_idle, st_setup, st_strobe, st_hold, st_read} phase_t;
endpackage

/* File: hdl/sram_sync2.sv */
// Purpose: two flop synchroniser for pin inputs
// Assumes: single ref_clk domain
// Notes: first flop is read only by the second
`timescale 1ns/1ps
module sram_sync2 #(
  parameter int unsigned width = 2
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [width-1:0] pin_in,
  output logic [width-1:0] pin_sync
);
  logic [width-1:0] stage_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage_reg <= '0;
      pin_sync <= '0;
    end else begin
      stage_reg <= pin_in;
      pin_sync <= stage_reg;
    end
  end
endmodule

/* File: hdl/sram_host_ctl.sv */
// Purpose: host controller driving a 256 x 1 asynchronous static ram
// Assumes: memory pins are clockless; outputs sampled through sram_sync2
// Notes: one access at a time; req taken only when ready is high
`timescale 1ns/1ps
module sram_host_ctl
(
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [sram_ctl_pkg::addr_w-1:0] req_addr,
  input wire logic req_wdata,
  output logic req_ready,
  output logic rsp_valid,
  output logic rsp_rdata,
  output logic rsp_error,
  output logic [sram_ctl_pkg::addr_w-1:0] mem_addr,
  output logic mem_sel_n,
  output logic mem_rw,
  output logic mem_din,
  input wire logic mem_dout,
  input wire logic mem_dout_n
);
  import sram_ctl_pkg::*;

  phase_t phase_reg;
  logic [cnt_w-1:0] cnt_reg;
  logic write_reg;
  logic [1:0] dout_sync;

  sram_sync2 #(.width(2)) u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .pin_in({mem_dout, mem_dout_n}),
    .pin_sync(dout_sync)
  );

  assign req_ready = (phase_reg == st_idle);

  // sequencing: select frames the whole access, rw is the timed strobe
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_reg <= st_idle;
      cnt_reg <= '0;
    end else begin
      unique case (phase_reg)
        st_idle: begin
          if (req_valid) begin
            cnt_reg <= '0;
            phase_reg <= req_write ? st_setup : st_read;
          end
        end
        st_setup: begin
          // address and data settle before strobe
          if (cnt_reg == cnt_w'(addr_setup_cyc - 1)) begin
            cnt_reg <= '0;
            phase_reg <= st_strobe;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        st_strobe: begin
          if (cnt_reg == cnt_w'(write_pulse_cyc - 1)) begin
            cnt_reg <= '0;
            phase_reg <= st_hold;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        st_read: begin
          // wait access time plus synchroniser delay
          if (cnt_reg == cnt_w'(access_cyc + 1)) begin
            cnt_reg <= '0;
            phase_reg <= st_hold;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        st_hold: begin
          if (cnt_reg == cnt_w'(hold_cyc - 1)) begin
            cnt_reg <= '0;
            phase_reg <= st_idle;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // pins: address and data latched at request, stable to the end
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_addr <= '0;
      mem_din <= 1'b0;
      write_reg <= 1'b0;
    end else if (phase_reg == st_idle && req_valid) begin
      mem_addr <= req_addr;
      mem_din <= req_wdata;
      write_reg <= req_write;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_sel_n <= 1'b1;
      mem_rw <= 1'b0;
    end else begin
      mem_sel_n <= !((phase_reg == st_idle && req_valid) ||
                     (phase_reg != st_idle && !(phase_reg == st_hold &&
                      cnt_reg == cnt_w'(hold_cyc - 1))));
      mem_rw <= (phase_reg == st_setup && cnt_reg == cnt_w'(addr_setup_cyc - 1)) ||
                (phase_reg == st_strobe && cnt_reg != cnt_w'(write_pulse_cyc - 1));
    end
  end

  // read and write answers: on reads true and complement must disagree
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 1'b0;
      rsp_error <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (phase_reg == st_read && cnt_reg == cnt_w'(access_cyc + 1)) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= dout_sync[1];
        rsp_error <= (dout_sync[1] == dout_sync[0]);
      end else if (phase_reg == st_hold && write_reg && cnt_reg == '0) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= dout_sync[1];
        rsp_error <= 1'b0;
      end
    end
  end

  // helper counter for strobe width
  logic [cnt_w-1:0] rw_len_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rw_len_reg <= '0;
    end else if (mem_rw) begin
      rw_len_reg <= rw_len_reg + 1'b1;
    end else begin
      rw_len_reg <= '0;
    end
  end

  // helper counter for select frame length
  logic [cnt_w-1:0] sel_len_reg;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_len_reg <= '0;
    end else if (!mem_sel_n) begin
      sel_len_reg <= sel_len_reg + 1'b1;
    end else begin
      sel_len_reg <= '0;
    end
  end

  a_rw_width: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(mem_rw) |-> rw_len_reg == cnt_w'(write_pulse_cyc))
    else $error("write strobe width wrong");
  a_rw_in_sel: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mem_rw |-> !mem_sel_n)
    else $error("write strobe without select");
  a_addr_stable: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !mem_sel_n && !$past(mem_sel_n) |-> $stable(mem_addr))
    else $error("address moved during access");
  a_data_stable: assert property (@(posedge ref_clk) disable iff (!arst_n)
    mem_rw || $fell(mem_rw) |-> $stable(mem_din))
    else $error("data moved during strobe");
  a_addr_setup: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(mem_rw) |-> !$past(mem_sel_n, 60) && $past(mem_addr, 60) == mem_addr)
    else $error("strobe before address setup");
  a_read_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
    phase_reg == st_read |-> !mem_rw && !mem_sel_n)
    else $error("read without rw low");
  a_ready_idle: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req_ready && req_valid |=> !req_ready && !mem_sel_n)
    else $error("request not taken");
  a_rd_rsp: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req_ready && req_valid && !req_write |-> ##[300:310] rsp_valid)
    else $error("read answer missing");
  a_sel_width: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(mem_sel_n) |-> sel_len_reg >= cnt_w'(addr_setup_cyc + write_pulse_cyc))
    else $error("select frame too short");
  a_din_setup: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(mem_rw) |-> $past(mem_din, 60) == mem_din)
    else $error("data set too late before strobe end");
  a_rw_read_low: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !write_reg |-> !mem_rw)
    else $error("write strobe during read");
  a_addr_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(mem_rw) |-> ##19 !mem_sel_n)
    else $error("select released too soon after strobe");
  a_wr_answer: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $fell(mem_rw) |=> rsp_valid)
    else $error("write answer missing");
  a_rsp_pulse: assert property (@(posedge ref_clk) disable iff (!arst_n)
    rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!arst_n)
    req_ready |-> mem_sel_n && !mem_rw)
    else $error("memory pins busy while idle");
  c_write: cover property (@(posedge ref_clk) $fell(mem_rw));
  c_read: cover property (@(posedge ref_clk) rsp_valid && !write_reg);
  c_err: cover property (@(posedge ref_clk) rsp_valid && rsp_error);
  c_wr_rsp: cover property (@(posedge ref_clk) rsp_valid && write_reg);
  c_read_ok: cover property (@(posedge ref_clk) rsp_valid && !write_reg && !rsp_error);
endmodule

/* File: bench/sram_256x1_model.sv */
// Purpose: behavioural 256 x 1 static ram standing on the memory pins
// Assumes: times in ns; acc_ns may be set below the slowest grade
// Notes: viol goes high on an address setup, strobe width, data setup or address-during-strobe fault by the controller
`timescale 1ns/1ps
module sram_256x1_model #(
  parameter int acc_ns = 1500
) (
  input wire logic [7:0] addr,
  input wire logic sel_n,
  input wire logic rw,
  input wire logic din,
  output logic dout,
  output logic dout_n,
  output logic viol
);
  logic cells [256];
  logic rd_ok = 0;
  int gen = 0;
  realtime t_addr = 0, t_rw = 0, t_din = 0;
  initial begin
    viol = 0;
    for (int i = 0; i < 256; i++) cells[i] = i[0];
  end
  // decode runs whatever select does; stale bit shown inverted until access time
  always @(addr) begin
    if (rw === 1'b1) viol = 1;
    t_addr = $realtime;
    gen = gen + 1;
    rd_ok = 0;
    fork
      automatic int g = gen;
      begin
        #(acc_ns);
        if (g == gen) rd_ok = 1;
      end
    join_none
  end
  always @(din) t_din = $realtime;
  always @(posedge rw) begin
    t_rw = $realtime;
    if (!sel_n && t_rw - t_addr < 300) viol = 1;
  end
  always @(negedge rw) begin
    if (!sel_n) begin
      if ($realtime - t_rw < 400 || $realtime - t_din < 300) viol = 1;
      else cells[addr] = din;
    end
  end
  always @* begin
    if (sel_n) dout = 1'bz;
    else if (rw) dout = din;
    else dout = rd_ok ? cells[addr] : ~cells[addr];
    dout_n = sel_n ? 1'bz : ~dout;
  end
endmodule

/* File: bench/sram_host_ctl_bench.sv */
// Purpose: self-checking bench for the static ram host controller
// Assumes: model answers faster than the controller waits
// Notes: driver queues expected responses, watcher pops and compares
`timescale 1ns/1ps
module sram_host_ctl_bench;
  import sram_ctl_pkg::*;
  logic ref_clk = 0, arst_n = 0, req_valid = 0, req_write = 0, req_wdata = 0;
  logic [addr_w-1:0] req_addr = '0, mem_addr, a;
  logic req_ready, rsp_valid, rsp_rdata, rsp_error, mem_sel_n, mem_rw, mem_din;
  logic mem_dout, mem_dout_n, viol;
  logic shadow [word_count];
  logic [1:0] expq [$];
  int err_total = 0, cmp_count = 0, cyc = 0, seed = 32'h3390;
  initial forever #2.5 ref_clk = ~ref_clk;
  sram_host_ctl i_sram_host_ctl(.ref_clk(ref_clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_error(rsp_error), .mem_addr(mem_addr),
    .mem_sel_n(mem_sel_n), .mem_rw(mem_rw), .mem_din(mem_din), .mem_dout(mem_dout),
    .mem_dout_n(mem_dout_n));
  sram_256x1_model #(.acc_ns(1400)) i_sram_256x1_model(.addr(mem_addr), .sel_n(mem_sel_n),
    .rw(mem_rw), .din(mem_din), .dout(mem_dout), .dout_n(mem_dout_n), .viol(viol));
  task automatic chk(input string nm, input logic [1:0] seen, input logic [1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic results();
    if (err_total == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // hold the request until taken, then note what the answer must carry
  task automatic access(input logic w, input logic [addr_w-1:0] ad, input logic d);
    req_valid <= 1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= d;
    @(posedge ref_clk);
    while (req_ready !== 1'b1) @(posedge ref_clk);
    if (w) shadow[ad] = d;
    expq.push_back({w ? d : shadow[ad], 1'b0});
    req_valid <= 0;
    @(posedge ref_clk);
  endtask
  always @(posedge ref_clk) begin
    if (arst_n && rsp_valid === 1'b1) begin
      if (expq.size() == 0) chk("extra", 2'b11, 2'b00);
      else chk("rsp", {rsp_rdata, rsp_error}, expq.pop_front());
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  initial begin
    for (int i = 0; i < word_count; i++) shadow[i] = i[0];
    repeat (10) @(posedge ref_clk);
    arst_n <= 1;
    access(1, 8'h00, 1);
    access(1, 8'hff, 0);
    access(0, 8'h00, 0);
    access(0, 8'hff, 0);
    repeat (12) begin
      a = 8'($random(seed));
      access(1, a, 1'($random(seed)));
      access(0, a, 0);
      access(0, 8'($random(seed)), 0);
    end
    while (expq.size() != 0) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk("pin timing", {1'b0, viol}, 2'b00);
    chk("missing", {1'b0, expq.size() != 0}, 2'b00);
    results();
  end
endmodule
